// *** pkg/sci_regs_pkg.sv ***
// constants for the serial data and rate register block
package sci_regs_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] CHAR_HOLD_OFS   = 8'h00;
   localparam logic [7:0] RATE_SEL_OFS    = 8'h04;
   localparam logic [7:0] TX_FINE_OFS     = 8'h08;
   localparam logic [7:0] RX_FINE_OFS     = 8'h0C;
   localparam logic [7:0] LINK_STATUS_OFS = 8'h10;

   // rate select field positions
   localparam int PRESCALE_MSB = 7;
   localparam int PRESCALE_LSB = 6;
   localparam int TX_DIV_MSB   = 5;
   localparam int TX_DIV_LSB   = 3;
   localparam int RX_DIV_MSB   = 2;
   localparam int RX_DIV_LSB   = 0;

   // link status bit positions
   localparam int STAT_TX_ROOM  = 0;
   localparam int STAT_TX_EMPTY = 1;
   localparam int STAT_RX_FULL  = 2;

   // reset values
   localparam logic [7:0] RATE_SEL_RST  = 8'h00;
   localparam logic [7:0] FINE_RST      = 8'h00;
   localparam logic [7:0] CHAR_HOLD_RST = 8'h00;

   // prescale factors per select code
   localparam logic [7:0] PRESCALE_F0 = 8'h01;
   localparam logic [7:0] PRESCALE_F1 = 8'h03;
   localparam logic [7:0] PRESCALE_F2 = 8'h04;
   localparam logic [7:0] PRESCALE_F3 = 8'h0D;

   // last count of the sample counter, sixteen sample ticks per bit tick
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;

   // depth of the transmit buffer
   localparam logic [1:0] TX_BUF_DEPTH = 2'h2;

endpackage

// *** src/sci_data_rate.sv ***
// serial data holding and baud rate generation behind an apb slave
//
// Contract
// - one address: writes fill transmit holding, reads receive holding
// - transmit holding takes a bus byte and hands it to the shifter
// - receive holding keeps the shifter's byte and returns it on read
// - reads give last received byte, writes load next byte, bit 7 msb
// - rate select is read/write and resets to zero, factors one
// - rate select: prescale bits 7:6, tx divisor 5:3, rx divisor 2:0
// - prescale codes 00,01,10,11 give factors 1,3,4,13
// - tx divisor code n divides by two to the n
// - rx divisor code n divides by two to the n, independent of tx
// - bit rate is clock over sixteen times prescale times divisor
// - nonzero fine prescaler divides that direction further, zero is off
`timescale 1ns/1ns
module sci_data_rate
   import sci_regs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_valid,
   output logic             rx_ready,
   output logic             tx_sample_tick,
   output logic             tx_bit_tick,
   output logic             rx_sample_tick,
   output logic             rx_bit_tick
);

   // prescale factor from the two select bits
   function automatic logic [7:0] prescale_factor(input logic [1:0] code);
      logic [7:0] f;
      f = PRESCALE_F0;
      case (code)
         2'h0:    f = PRESCALE_F0;
         2'h1:    f = PRESCALE_F1;
         2'h2:    f = PRESCALE_F2;
         2'h3:    f = PRESCALE_F3;
         default: f = PRESCALE_F0;
      endcase
      return f;
   endfunction

   // last count of a power of two divider
   function automatic logic [7:0] div_last(input logic [2:0] code);
      logic [7:0] p;
      p = 8'h01 << code;
      return p - 8'h01;
   endfunction

   // last count of the fine prescaler, zero meaning off
   function automatic logic [7:0] fine_last(input logic [7:0] v);
      logic [7:0] l;
      l = (v == 8'h00) ? 8'h00 : v - 8'h01;
      return l;
   endfunction

   // register state
   logic [7:0]  rate_sel_r,  rate_sel_nxt;
   logic [7:0]  tx_fine_r,   tx_fine_nxt;
   logic [7:0]  rx_fine_r,   rx_fine_nxt;
   logic [7:0]  rx_hold_r,   rx_hold_nxt;
   logic        rx_full_r,   rx_full_nxt;
   logic        rx_ready_r,  rx_ready_nxt;
   logic [31:0] prdata_r,    prdata_nxt;
   logic        pready_r,    pready_nxt;
   logic        pslverr_r,   pslverr_nxt;

   // transmit buffer, entry 0 is the head
   logic [7:0]  tx_buf_r  [2];
   logic [7:0]  tx_buf_nxt[2];
   logic [1:0]  tx_cnt_r,   tx_cnt_nxt;
   logic        tx_valid_r, tx_valid_nxt;

   // decoded bus access
   logic        access;
   logic        done;
   logic        mapped;
   logic        data_wr;
   logic        data_rd;
   logic        tx_full;
   logic        tx_pop;
   logic [1:0]  cnt_after_pop;
   logic [7:0]  pr_last;

   // shared prescale stage
   logic [7:0]  pre_cnt_r, pre_cnt_nxt;
   logic        pre_tick;

   assign access  = psel & penable;
   assign done    = access & pready_r;
   assign mapped  = (paddr == CHAR_HOLD_OFS) | (paddr == RATE_SEL_OFS)
                  | (paddr == TX_FINE_OFS)   | (paddr == RX_FINE_OFS)
                  | (paddr == LINK_STATUS_OFS);
   assign data_wr = done & pwrite & (paddr == CHAR_HOLD_OFS) & mapped;
   assign data_rd = done & ~pwrite & (paddr == CHAR_HOLD_OFS);
   assign tx_full = (tx_cnt_r == TX_BUF_DEPTH);
   assign tx_pop  = tx_valid_r & tx_ready;
   assign pr_last = prescale_factor(rate_sel_r[PRESCALE_MSB:PRESCALE_LSB])
                  - 8'h01;
   assign pre_tick = (pre_cnt_r == pr_last);

   // apb answer: one wait cycle, longer while a data write finds no room
   always_comb
   begin
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt  = prdata_r;
      if (access & ~pready_r)
      begin
         if (~(pwrite & (paddr == CHAR_HOLD_OFS) & tx_full))
         begin
            pready_nxt  = 1'b1;
            pslverr_nxt = ~mapped;
            prdata_nxt  = 32'h0000_0000;
            case (paddr)
               CHAR_HOLD_OFS:   prdata_nxt[7:0] = rx_hold_r;
               RATE_SEL_OFS:    prdata_nxt[7:0] = rate_sel_r;
               TX_FINE_OFS:     prdata_nxt[7:0] = tx_fine_r;
               RX_FINE_OFS:     prdata_nxt[7:0] = rx_fine_r;
               LINK_STATUS_OFS:
               begin
                  prdata_nxt[STAT_TX_ROOM]  = ~tx_full;
                  prdata_nxt[STAT_TX_EMPTY] = (tx_cnt_r == 2'h0);
                  prdata_nxt[STAT_RX_FULL]  = rx_full_r;
               end
               default:         prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // configuration registers written at the completing edge
   always_comb
   begin
      rate_sel_nxt = rate_sel_r;
      tx_fine_nxt  = tx_fine_r;
      rx_fine_nxt  = rx_fine_r;
      if (done & pwrite)
      begin
         case (paddr)
            RATE_SEL_OFS: rate_sel_nxt = pwdata[7:0];
            TX_FINE_OFS:  tx_fine_nxt  = pwdata[7:0];
            RX_FINE_OFS:  rx_fine_nxt  = pwdata[7:0];
            default:      rate_sel_nxt = rate_sel_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rate_sel_r <= RATE_SEL_RST;
         tx_fine_r  <= FINE_RST;
         rx_fine_r  <= FINE_RST;
      end
      else
      begin
         rate_sel_r <= rate_sel_nxt;
         tx_fine_r  <= tx_fine_nxt;
         rx_fine_r  <= rx_fine_nxt;
      end
   end

   // transmit buffer: bus pushes, shifter pops from entry 0
   always_comb
   begin
      tx_buf_nxt[0] = tx_buf_r[0];
      tx_buf_nxt[1] = tx_buf_r[1];
      tx_cnt_nxt    = tx_cnt_r;
      cnt_after_pop = tx_cnt_r;
      if (tx_pop)
      begin
         tx_buf_nxt[0] = tx_buf_r[1];
         cnt_after_pop = tx_cnt_r - 2'h1;
      end
      tx_cnt_nxt = cnt_after_pop;
      if (data_wr)
      begin
         tx_buf_nxt[cnt_after_pop[0]] = pwdata[7:0];
         tx_cnt_nxt = cnt_after_pop + 2'h1;
      end
      tx_valid_nxt = (tx_cnt_nxt != 2'h0);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_buf_r[0] <= CHAR_HOLD_RST;
         tx_buf_r[1] <= CHAR_HOLD_RST;
         tx_cnt_r    <= 2'h0;
         tx_valid_r  <= 1'b0;
      end
      else
      begin
         tx_buf_r[0] <= tx_buf_nxt[0];
         tx_buf_r[1] <= tx_buf_nxt[1];
         tx_cnt_r    <= tx_cnt_nxt;
         tx_valid_r  <= tx_valid_nxt;
      end
   end

   // receive holding: filled by the shifter, emptied by a data read
   always_comb
   begin
      rx_hold_nxt = rx_hold_r;
      rx_full_nxt = rx_full_r;
      if (data_rd)
      begin
         rx_full_nxt = 1'b0;
      end
      if (rx_valid & rx_ready_r)
      begin
         rx_hold_nxt = rx_data;
         rx_full_nxt = 1'b1;
      end
      rx_ready_nxt = ~rx_full_nxt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_hold_r  <= CHAR_HOLD_RST;
         rx_full_r  <= 1'b0;
         rx_ready_r <= 1'b1;
      end
      else
      begin
         rx_hold_r  <= rx_hold_nxt;
         rx_full_r  <= rx_full_nxt;
         rx_ready_r <= rx_ready_nxt;
      end
   end

   // shared prescale counter, wraps at the selected factor
   always_comb
   begin
      pre_cnt_nxt = pre_tick ? 8'h00 : pre_cnt_r + 8'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_cnt_r <= 8'h00;
      end
      else
      begin
         pre_cnt_r <= pre_cnt_nxt;
      end
   end

   // per direction: divisor, fine prescaler and divide by sixteen
   for (genvar d = 0; d < 2; d++)
   begin : g_dir
      logic [2:0] code;
      logic [7:0] fine_val;
      logic [7:0] div_cnt_r,  div_cnt_nxt;
      logic [7:0] fine_cnt_r, fine_cnt_nxt;
      logic [3:0] six_cnt_r,  six_cnt_nxt;
      logic       samp_r,     samp_nxt;
      logic       bit_r,      bit_nxt;
      logic       div_tick;
      logic       fine_tick;

      // direction 0 transmits, direction 1 receives
      assign code = (d == 0) ? rate_sel_r[TX_DIV_MSB:TX_DIV_LSB]
                             : rate_sel_r[RX_DIV_MSB:RX_DIV_LSB];
      assign fine_val  = (d == 0) ? tx_fine_r : rx_fine_r;
      assign div_tick  = pre_tick & (div_cnt_r == div_last(code));
      assign fine_tick = div_tick
                       & (fine_cnt_r == fine_last(fine_val));

      // next counts and tick pulses
      always_comb
      begin
         div_cnt_nxt  = div_cnt_r;
         fine_cnt_nxt = fine_cnt_r;
         six_cnt_nxt  = six_cnt_r;
         samp_nxt     = fine_tick;
         bit_nxt      = 1'b0;
         if (pre_tick)
         begin
            div_cnt_nxt = div_tick ? 8'h00 : div_cnt_r + 8'h01;
         end
         if (div_tick)
         begin
            fine_cnt_nxt = fine_tick ? 8'h00 : fine_cnt_r + 8'h01;
         end
         if (fine_tick)
         begin
            six_cnt_nxt = six_cnt_r + 4'h1;
            bit_nxt     = (six_cnt_r == OVERSAMPLE_LAST);
         end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            div_cnt_r  <= 8'h00;
            fine_cnt_r <= 8'h00;
            six_cnt_r  <= 4'h0;
            samp_r     <= 1'b0;
            bit_r      <= 1'b0;
         end
         else
         begin
            div_cnt_r  <= div_cnt_nxt;
            fine_cnt_r <= fine_cnt_nxt;
            six_cnt_r  <= six_cnt_nxt;
            samp_r     <= samp_nxt;
            bit_r      <= bit_nxt;
         end
      end
   end

   // outputs taken straight from flip-flops
   assign prdata         = prdata_r;
   assign pready         = pready_r;
   assign pslverr        = pslverr_r;
   assign tx_data        = tx_buf_r[0];
   assign tx_valid       = tx_valid_r;
   assign rx_ready       = rx_ready_r;
   assign tx_sample_tick = g_dir[0].samp_r;
   assign tx_bit_tick    = g_dir[0].bit_r;
   assign rx_sample_tick = g_dir[1].samp_r;
   assign rx_bit_tick    = g_dir[1].bit_r;

endmodule

// *** tb/sci_data_rate_asserts.sv ***
// port-level checks for the serial data and rate block
`timescale 1ns/1ns
module sci_data_rate_asserts
   import sci_regs_pkg::*;
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [7:0]  tx_data,
   input logic        tx_valid,
   input logic        tx_ready,
   input logic        rx_valid,
   input logic        rx_ready,
   input logic        tx_sample_tick,
   input logic        tx_bit_tick,
   input logic        rx_sample_tick,
   input logic        rx_bit_tick
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus answer timing and content
   chk_first_wait: assert property (psel && penable && !$past(penable)
      |-> !pready) else $error("no wait cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   // transmit holding hand-off
   chk_tx_push: assert property (pready && pwrite
      && paddr == CHAR_HOLD_OFS |=> tx_valid)
      else $error("written byte not offered");
   chk_tx_hold: assert property (tx_valid && !tx_ready
      |=> tx_valid && $stable(tx_data)) else $error("byte dropped");
   // receive holding capture and release
   chk_rx_take: assert property (rx_valid && rx_ready
      |=> !rx_ready) else $error("holding not marked full");
   chk_rx_free: assert property (pready && !pwrite
      && paddr == CHAR_HOLD_OFS && !rx_ready |=> rx_ready)
      else $error("holding not freed");
   chk_rx_keep: assert property (!rx_ready
      && !(pready && !pwrite && paddr == CHAR_HOLD_OFS) |=> !rx_ready)
      else $error("holding freed without read");
   // bit tick falls on a sample tick
   chk_tx_align: assert property (tx_bit_tick |-> tx_sample_tick)
      else $error("tx bit tick off sample");
   chk_rx_align: assert property (rx_bit_tick |-> rx_sample_tick)
      else $error("rx bit tick off sample");
endmodule
bind sci_data_rate sci_data_rate_asserts u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .tx_data, .tx_valid,
   .tx_ready, .rx_valid, .rx_ready, .tx_sample_tick, .tx_bit_tick,
   .rx_sample_tick, .rx_bit_tick);

// *** tb/sci_shifter_model.sv ***
// line side shifter model: drains transmit bytes, offers received bytes
`timescale 1ns/1ns
module sci_shifter_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   input  wire logic        stall,
   input  wire logic        rx_push,
   input  wire logic [7:0]  rx_byte,
   output logic [23:0]      tx_log
);
   // shifter busy while stalled
   assign tx_ready = !stall;
   // log popped bytes, hold an offered byte until taken
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_log   <= 24'h000000;
         rx_valid <= 1'b0;
         rx_data  <= 8'h00;
      end
      else
      begin
         if (tx_valid && tx_ready)
            tx_log <= {tx_log[15:0], tx_data};
         if (rx_push)
         begin
            rx_valid <= 1'b1;
            rx_data  <= rx_byte;
         end
         else if (rx_valid && rx_ready)
         begin
            rx_valid <= 1'b0;
            rx_data  <= ~rx_data; // released line shows the inverse
         end
      end
endmodule

// *** tb/tb_sci_data_rate.sv ***
// register, stream and rate tick tests for the serial block
`timescale 1ns/1ns
module tb_sci_data_rate
   import sci_regs_pkg::*;
;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
   logic [7:0]  tx_data, rx_data;
   wire  [3:0]  tk;
   logic        stall = 0;
   logic        rx_push = 0;
   logic [7:0]  rx_byte = 8'h00;
   logic [23:0] tx_log;
   logic [31:0] d;
   logic        e;
   int          err_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          p;
   int          pf[4] = '{1, 3, 4, 13};
   logic [7:0]  tbl[6] = '{8'h00, 8'h4A, 8'h96, 8'hE0, 8'h38, 8'h07};
   always #5 pclk = ~pclk;
   sci_data_rate u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_data, .tx_valid, .tx_ready,
      .rx_data, .rx_valid, .rx_ready, .tx_sample_tick(tk[0]),
      .tx_bit_tick(tk[1]), .rx_sample_tick(tk[2]), .rx_bit_tick(tk[3]));
   sci_shifter_model u_line (.pclk, .presetn, .tx_data, .tx_valid, .tx_ready,
      .rx_data, .rx_valid, .rx_ready, .stall, .rx_push, .rx_byte, .tx_log);
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   // cycles between two consecutive pulses of one tick
   task automatic meas(input int k);
      do @(posedge pclk); while (tk[k] !== 1'b1);
      p = 0;
      do
      begin
         @(posedge pclk);
         p++;
      end
      while (tk[k] !== 1'b1);
   endtask
   task automatic rate(input logic [7:0] v, input int et, input int er);
      apb(1, RATE_SEL_OFS, {24'h0, v}); // line model idle here
      apb(0, RATE_SEL_OFS, 0);
      cmp(d, {24'h0, v});
      meas(0);
      meas(0);
      cmp(p, pf[v[7:6]] * (1 << v[5:3]) * et);
      meas(2);
      meas(2);
      cmp(p, pf[v[7:6]] * (1 << v[2:0]) * er);
   endtask
   task report_and_stop;
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, RATE_SEL_OFS, 0);
      cmp(d, 0);
      apb(0, 8'h14, 0);
      cmp(e, 1);
      cmp(d, 0);
      meas(1);
      meas(1);
      cmp(p, 16);
      meas(3);
      meas(3);
      cmp(p, 16);
      foreach (tbl[i]) rate(tbl[i], 1, 1);
      apb(1, TX_FINE_OFS, 3);
      apb(1, RX_FINE_OFS, 2);
      apb(0, TX_FINE_OFS, 0);
      cmp(d, 3);
      rate(8'h4A, 3, 2);
      // reset in mid-run clears rate select and the rx fine prescaler
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      cmp({tx_valid, rx_ready}, 1);
      apb(0, RATE_SEL_OFS, 0);
      cmp(d, 0);
      apb(0, RX_FINE_OFS, 0);
      cmp(d, 0);
      // fill the transmit buffer against a stalled shifter, then drain
      stall <= 1;
      apb(1, CHAR_HOLD_OFS, 8'h81);
      apb(1, CHAR_HOLD_OFS, 8'h3C);
      apb(0, LINK_STATUS_OFS, 0);
      cmp(d[STAT_TX_ROOM], 0);
      fork
         apb(1, CHAR_HOLD_OFS, 8'h5A);
         begin
            repeat (30) @(posedge pclk);
            stall <= 0;
         end
      join
      repeat (6) @(posedge pclk);
      cmp(tx_log, 24'h813C5A);
      apb(0, LINK_STATUS_OFS, 0);
      cmp(d[STAT_TX_EMPTY], 1);
      // two received bytes, the second waits for the first read
      rx_byte <= 8'hA5;
      rx_push <= 1;
      @(posedge pclk) rx_push <= 0;
      apb(0, LINK_STATUS_OFS, 0);
      cmp(d[STAT_RX_FULL], 1);
      rx_byte <= 8'h42;
      rx_push <= 1;
      @(posedge pclk) rx_push <= 0;
      repeat (4) @(posedge pclk);
      apb(0, CHAR_HOLD_OFS, 0);
      cmp(d, 32'hA5);
      repeat (3) @(posedge pclk);
      apb(0, CHAR_HOLD_OFS, 0);
      cmp(d, 32'h42);
      report_and_stop;
   end
endmodule
